// ### src/tog_consts.svh
// constants of the table offset directory and general settings block
`ifndef TOG_CONSTS_SVH
`define TOG_CONSTS_SVH

// ************************************************************
// register byte addresses within the memory window
// ************************************************************
`define TOG_ADDR_W         12
`define TOG_ADDR_DIR_W0    12'h060
`define TOG_ADDR_DIR_W1    12'h064
`define TOG_ADDR_DIR_W2    12'h068
`define TOG_ADDR_DIR_W3    12'h06c
`define TOG_ADDR_GENSET    12'h080

// ************************************************************
// table offset directory: each field counts 0x100-byte units
// ************************************************************
`define TOG_OFS_UNIT_SHIFT 8
`define TOG_OFS_FLD_W      16
`define TOG_OFS_BYTE_W     24
`define TOG_OFS_UNIT_MASK  24'h0000ff
// default byte offsets of the tables (placement is implementation defined)
`define TOG_DEF_GRP_OFS    24'h000400
`define TOG_DEF_WQ_OFS     24'h000500
`define TOG_DEF_MSIX_OFS   24'h000600
`define TOG_DEF_IMS_OFS    24'h001000
`define TOG_DEF_PERF_OFS   24'h002000
`define TOG_DEF_INTER_DOMAIN_PERMISSION_TABLE_OFS   24'h003000

// ************************************************************
// general settings field positions
// ************************************************************
`define TOG_GS_EVLOG_BIT   13
`define TOG_GS_UINTR_BIT   12
`define TOG_GS_LIMIT_HI    7
`define TOG_GS_LIMIT_LO    0
`define TOG_GS_RSVD_HI_W   18
`define TOG_GS_RSVD_MID_W  4

// ************************************************************
// device state codes and misc
// ************************************************************
`define TOG_STATE_DISABLED 2'h0
`define TOG_RBUF_CNT_W     9
`define TOG_RBUF_ONE       9'h001
`define TOG_RBUF_ZERO      9'h000
`define TOG_WORD_ZERO      32'h0000_0000

`endif

// ### src/tog_pkg.sv
// types shared by the table offset directory and general settings block
package tog_pkg;
  typedef logic [1:0]  tog_dev_state_t;
  typedef logic [19:0] tog_pasid_t;
  typedef logic [7:0]  tog_rbuf_t;
endpackage

// ### src/tog_regs.sv
// table offset directory and lockable general settings register with their users
`timescale 1ns/1ns
`default_nettype none
`include "tog_consts.svh"

// Behaviour
// - inter-domain permission table offset sits in directory bits 95:80, units of 0x100.
// - performance counter block offset sits in directory bits 79:64, units of 0x100.
// - interrupt message storage offset sits in directory bits 63:48, units of 0x100.
// - MSI-X permission table offset sits in directory bits 47:32, units of 0x100.
// - work queue configuration table offset sits in directory bits 31:16, units 0x100.
// - group configuration table offset sits in directory bits 15:0, units of 0x100.
// - general settings accept writes only while disabled, read-only otherwise.
// - without configuration support, user interrupt enable and buffer limit stay read-only.
// - event log enable set sends every event, software errors too, to the log.
// - event log enable is reserved when event log support is absent.
// - user interrupt enable clear forbids user descriptors from requesting completion interrupts.
// - user completion interrupt fires only when entry and descriptor PASIDs match.
// - global limit caps read buffers held by low-bandwidth descriptors of opted-in groups device-wide.
// - global limit starts at the total read buffer count from group capability.
// - global limit applies only to groups whose use-global flag is one.
// - global limit field is reserved when global limit support is absent.
// - device state 00 is disabled, does no work, and unlocks general settings.
module tog_regs #(
  parameter logic [`TOG_OFS_BYTE_W-1:0] GRP_OFS  = `TOG_DEF_GRP_OFS,
  parameter logic [`TOG_OFS_BYTE_W-1:0] WQ_OFS   = `TOG_DEF_WQ_OFS,
  parameter logic [`TOG_OFS_BYTE_W-1:0] MSIX_OFS = `TOG_DEF_MSIX_OFS,
  parameter logic [`TOG_OFS_BYTE_W-1:0] IMS_OFS  = `TOG_DEF_IMS_OFS,
  parameter logic [`TOG_OFS_BYTE_W-1:0] PERF_OFS = `TOG_DEF_PERF_OFS,
  parameter logic [`TOG_OFS_BYTE_W-1:0] INTER_DOMAIN_PERMISSION_TABLE_OFS = `TOG_DEF_INTER_DOMAIN_PERMISSION_TABLE_OFS
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic [`TOG_ADDR_W-1:0]  reg_addr_i,
  input  wire logic                    reg_wr_i,
  input  wire logic [31:0]             reg_wdata_i,
  input  wire logic                    reg_rd_i,
  output logic      [31:0]             reg_rdata_o,
  output logic                         reg_rvalid_o,
  input  wire tog_pkg::tog_dev_state_t dev_state_i,
  input  wire logic                    cfg_support_i,
  input  wire logic                    evlog_support_i,
  input  wire logic                    glimit_support_i,
  input  wire tog_pkg::tog_rbuf_t      total_rbuf_i,
  input  wire logic                    evt_valid_i,
  input  wire logic                    evt_swerr_i,
  output logic                         evlog_wr_o,
  output logic                         swerr_rec_o,
  input  wire logic                    cmp_valid_i,
  input  wire logic                    cmp_user_i,
  input  wire logic                    cmp_intr_req_i,
  input  wire tog_pkg::tog_pasid_t     cmp_desc_pasid_i,
  input  wire tog_pkg::tog_pasid_t     cmp_entry_pasid_i,
  output logic                         cmp_intr_o,
  output logic                         cmp_blocked_o,
  input  wire logic                    rb_req_i,
  input  wire logic                    rb_low_bw_i,
  input  wire logic                    rb_use_global_i,
  input  wire logic                    rb_rel_i,
  input  wire logic                    rb_rel_global_i,
  output logic                         rb_grant_o,
  output logic                         rb_deny_o,
  output logic [`TOG_RBUF_CNT_W-1:0]   rb_held_o,
  output logic                         evlog_en_o,
  output logic                         user_intr_en_o,
  output tog_pkg::tog_rbuf_t           glimit_o
);
  import tog_pkg::*;

  // ************************************************************
  // directory fields
  // ************************************************************
  localparam logic [`TOG_OFS_FLD_W-1:0] GRP_FLD  =
    GRP_OFS[`TOG_OFS_UNIT_SHIFT +: `TOG_OFS_FLD_W];
  localparam logic [`TOG_OFS_FLD_W-1:0] WQ_FLD   =
    WQ_OFS[`TOG_OFS_UNIT_SHIFT +: `TOG_OFS_FLD_W];
  localparam logic [`TOG_OFS_FLD_W-1:0] MSIX_FLD =
    MSIX_OFS[`TOG_OFS_UNIT_SHIFT +: `TOG_OFS_FLD_W];
  localparam logic [`TOG_OFS_FLD_W-1:0] IMS_FLD  =
    IMS_OFS[`TOG_OFS_UNIT_SHIFT +: `TOG_OFS_FLD_W];
  localparam logic [`TOG_OFS_FLD_W-1:0] PERF_FLD =
    PERF_OFS[`TOG_OFS_UNIT_SHIFT +: `TOG_OFS_FLD_W];
  localparam logic [`TOG_OFS_FLD_W-1:0] INTER_DOMAIN_PERMISSION_TABLE_FLD =
    INTER_DOMAIN_PERMISSION_TABLE_OFS[`TOG_OFS_UNIT_SHIFT +: `TOG_OFS_FLD_W];

  logic [31:0] dir_w0;
  logic [31:0] dir_w1;
  logic [31:0] dir_w2;
  assign dir_w0 = {WQ_FLD, GRP_FLD};
  assign dir_w1 = {IMS_FLD, MSIX_FLD};
  assign dir_w2 = {INTER_DOMAIN_PERMISSION_TABLE_FLD, PERF_FLD};

  // ************************************************************
  // settings state
  // ************************************************************
  logic      evlog_en_q;
  logic      uintr_en_q;
  tog_rbuf_t glimit_q;
  logic      disabled;
  logic      gs_wr;
  logic      work_ok;

  assign disabled = (dev_state_i == `TOG_STATE_DISABLED);
  assign work_ok  = !disabled;
  assign gs_wr    = reg_wr_i && (reg_addr_i == `TOG_ADDR_GENSET) && disabled;

  // event log enable: reserved bit when the log is not supported
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evlog_en_q <= 1'b0;
    end else if (!evlog_support_i) begin
      evlog_en_q <= 1'b0;
    end else if (gs_wr) begin
      evlog_en_q <= reg_wdata_i[`TOG_GS_EVLOG_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      uintr_en_q <= 1'b0;
    end else if (gs_wr && cfg_support_i) begin
      uintr_en_q <= reg_wdata_i[`TOG_GS_UINTR_BIT];
    end
  end

  // reset is synchronous, so loading the capability count here is a clocked capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      glimit_q <= total_rbuf_i;
    end else if (gs_wr && cfg_support_i && glimit_support_i) begin
      glimit_q <= reg_wdata_i[`TOG_GS_LIMIT_HI:`TOG_GS_LIMIT_LO];
    end
  end

  // ************************************************************
  // register read port: answer one cycle after the strobe
  // ************************************************************
  logic [31:0] gs_word;
  logic [31:0] rd_mux;

  always_comb begin
    gs_word = {{`TOG_GS_RSVD_HI_W{1'b0}}, evlog_en_q && evlog_support_i, uintr_en_q,
               {`TOG_GS_RSVD_MID_W{1'b0}},
               glimit_support_i ? glimit_q : tog_rbuf_t'(0)};
    case (reg_addr_i)
      `TOG_ADDR_DIR_W0: rd_mux = dir_w0;
      `TOG_ADDR_DIR_W1: rd_mux = dir_w1;
      `TOG_ADDR_DIR_W2: rd_mux = dir_w2;
      `TOG_ADDR_GENSET: rd_mux = gs_word;
      default:          rd_mux = `TOG_WORD_ZERO;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_rdata_o  <= `TOG_WORD_ZERO;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      reg_rdata_o  <= reg_rd_i ? rd_mux : `TOG_WORD_ZERO;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evlog_en_o     <= 1'b0;
      user_intr_en_o <= 1'b0;
      glimit_o       <= '0;
    end else begin
      evlog_en_o     <= evlog_en_q && evlog_support_i;
      user_intr_en_o <= uintr_en_q;
      glimit_o       <= glimit_q;
    end
  end

  // ************************************************************
  // event routing
  // ************************************************************
  // with the log off, only software errors are kept, in the error record
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evlog_wr_o  <= 1'b0;
      swerr_rec_o <= 1'b0;
    end else begin
      evlog_wr_o  <= work_ok && evt_valid_i && evlog_en_q && evlog_support_i;
      swerr_rec_o <= work_ok && evt_valid_i && evt_swerr_i &&
                     !(evlog_en_q && evlog_support_i);
    end
  end

  // ************************************************************
  // completion interrupt gating
  // ************************************************************
  logic cmp_ask;
  logic user_ok;
  assign cmp_ask = work_ok && cmp_valid_i && cmp_intr_req_i;
  // a user request needs the enable and a PASID match on the table entry
  assign user_ok = uintr_en_q && (cmp_entry_pasid_i == cmp_desc_pasid_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_intr_o    <= 1'b0;
      cmp_blocked_o <= 1'b0;
    end else begin
      cmp_intr_o    <= cmp_ask && (!cmp_user_i || user_ok);
      cmp_blocked_o <= cmp_ask && cmp_user_i && !user_ok;
    end
  end

  // ************************************************************
  // global read buffer accounting
  // ************************************************************
  logic [`TOG_RBUF_CNT_W-1:0] held_q;
  logic                       counted;
  logic                       room;
  logic                       take;
  logic                       give;

  // only low-bandwidth requests from groups that opted in are counted
  assign counted = rb_low_bw_i && rb_use_global_i && glimit_support_i;
  assign room    = held_q < {1'b0, glimit_q};
  assign take    = work_ok && rb_req_i && counted && room;
  assign give    = rb_rel_i && rb_rel_global_i && (held_q != `TOG_RBUF_ZERO);

  // releases are honoured even while disabled so outstanding buffers drain
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      held_q <= `TOG_RBUF_ZERO;
    end else if (take && !give) begin
      held_q <= held_q + `TOG_RBUF_ONE;
    end else if (give && !take) begin
      held_q <= held_q - `TOG_RBUF_ONE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rb_grant_o <= 1'b0;
      rb_deny_o  <= 1'b0;
      rb_held_o  <= `TOG_RBUF_ZERO;
    end else begin
      rb_grant_o <= work_ok && rb_req_i && (!counted || room);
      rb_deny_o  <= work_ok && rb_req_i && counted && !room;
      rb_held_o  <= held_q;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  gs_lock_a: assert property (
    (reg_wr_i && reg_addr_i == `TOG_ADDR_GENSET && !disabled) |=>
      $stable(uintr_en_q) && $stable(glimit_q))
    else $error("general settings changed by a write while not disabled");

  cfg_ro_a: assert property (
    !cfg_support_i |=> $stable(uintr_en_q) && $stable(glimit_q))
    else $error("read-only settings changed without configuration support");

  evlog_route_a: assert property (
    (work_ok && evt_valid_i && evlog_en_q && evlog_support_i) |=>
      evlog_wr_o && !swerr_rec_o)
    else $error("event not written to the log while logging is enabled");

  evlog_rsvd_a: assert property (
    (!evlog_support_i && reg_rd_i && reg_addr_i == `TOG_ADDR_GENSET) |=>
      reg_rvalid_o && !reg_rdata_o[`TOG_GS_EVLOG_BIT])
    else $error("unsupported event log enable read back as one");

  uintr_block_a: assert property (
    (cmp_ask && cmp_user_i && !uintr_en_q) |=> !cmp_intr_o && cmp_blocked_o)
    else $error("user completion interrupt raised with user interrupts off");

  pasid_match_a: assert property (
    (cmp_ask && cmp_user_i && cmp_entry_pasid_i != cmp_desc_pasid_i) |=>
      !cmp_intr_o && cmp_blocked_o)
    else $error("completion interrupt raised on a PASID mismatch");

  rbuf_cap_a: assert property (
    (work_ok && rb_req_i && counted && held_q >= {1'b0, glimit_q}) |=>
      rb_deny_o && !rb_grant_o && held_q <= $past(held_q))
    else $error("read buffer granted beyond the global limit");

  rbuf_local_a: assert property (
    (work_ok && rb_req_i && !rb_use_global_i && !(rb_rel_i && rb_rel_global_i)) |=>
      rb_grant_o && $stable(held_q))
    else $error("group outside the global limit was counted or refused");

  glimit_init_a: assert property (
    $fell(rst_i) |-> glimit_q == $past(total_rbuf_i))
    else $error("global limit did not start at the total buffer count");

  dir_read_a: assert property (
    (reg_rd_i && reg_addr_i == `TOG_ADDR_DIR_W0) |=>
      reg_rdata_o[`TOG_OFS_FLD_W-1:0] == GRP_FLD &&
      reg_rdata_o[31:`TOG_OFS_FLD_W] == WQ_FLD)
    else $error("directory word zero did not show the table offsets");

  dir_mid_a: assert property (
    (reg_rd_i && reg_addr_i == `TOG_ADDR_DIR_W1) |=>
      reg_rdata_o[`TOG_OFS_FLD_W-1:0] == MSIX_FLD &&
      reg_rdata_o[31:`TOG_OFS_FLD_W] == IMS_FLD)
    else $error("directory word one did not show the table offsets");

  dir_high_a: assert property (
    (reg_rd_i && reg_addr_i == `TOG_ADDR_DIR_W2) |=>
      reg_rdata_o[`TOG_OFS_FLD_W-1:0] == PERF_FLD &&
      reg_rdata_o[31:`TOG_OFS_FLD_W] == INTER_DOMAIN_PERMISSION_TABLE_FLD)
    else $error("directory word two did not show the table offsets");

  gs_write_a: assert property (
    (reg_wr_i && reg_addr_i == `TOG_ADDR_GENSET && dev_state_i == `TOG_STATE_DISABLED &&
     cfg_support_i && glimit_support_i) |=>
      glimit_q == $past(reg_wdata_i[`TOG_GS_LIMIT_HI:`TOG_GS_LIMIT_LO]))
    else $error("general settings write while disabled did not land");

  swerr_keep_a: assert property (
    (work_ok && evt_valid_i && evt_swerr_i) |=> evlog_wr_o || swerr_rec_o)
    else $error("software error event was neither logged nor recorded");

  glimit_rsvd_a: assert property (
    (!glimit_support_i && reg_rd_i && reg_addr_i == `TOG_ADDR_GENSET) |=>
      reg_rdata_o[`TOG_GS_LIMIT_HI:`TOG_GS_LIMIT_LO] == '0)
    else $error("unsupported global limit read back as nonzero");

  idle_work_a: assert property (
    disabled |=> !evlog_wr_o && !cmp_intr_o && !rb_grant_o)
    else $error("work performed while the device was disabled");

  rsvd_zero_a: assert property (
    (reg_rd_i && reg_addr_i == `TOG_ADDR_GENSET) |=>
      reg_rdata_o[31:`TOG_GS_EVLOG_BIT+1] == '0 &&
      reg_rdata_o[`TOG_GS_UINTR_BIT-1:`TOG_GS_LIMIT_HI+1] == '0)
    else $error("reserved settings bits read back as nonzero");

endmodule
`default_nettype wire

// ### sim/tog_regs_bench.sv
// self-checking bench of the table offset directory and general settings block
`timescale 1ns/1ns
`default_nettype none
`include "tog_consts.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end

module tog_regs_bench;
  import tog_pkg::*;
  // ************************************************************
  // signals and stimulus rows
  // ************************************************************
  typedef struct packed {
    logic [1:0]  st;
    logic        cfg;
    logic        evs;
    logic        gls;
    logic [31:0] wd;
    logic [31:0] rd;
  } tog_row_t;
  // write under each lock state and with each capability dropped in turn, then the value read back
  tog_row_t rows [8] = '{
    {2'h0, 3'b111, 32'hffff_ffff, 32'h0000_30ff}, {2'h1, 3'b111, 32'h0000_0000, 32'h0000_30ff},
    {2'h0, 3'b111, 32'h0000_0003, 32'h0000_0003}, {2'h0, 3'b011, 32'hffff_ffff, 32'h0000_2003},
    {2'h0, 3'b101, 32'h0000_0000, 32'h0000_0000}, {2'h0, 3'b110, 32'h0000_10aa, 32'h0000_1000},
    {2'h2, 3'b111, 32'hffff_ffff, 32'h0000_1000}, {2'h3, 3'b111, 32'h0000_0000, 32'h0000_1000}};
  // directory words for the offsets handed to the instance, field = byte offset / 0x100;
  // the perf block is left at its default placement
  logic [31:0]    dir_exp [5] = '{32'h0013_0012, 32'h00a0_0045, 32'hfe00_0020, 32'h0, 32'h0};
  int             errors;
  int             checked;
  logic           clk_i, rst_i, reg_wr_i, reg_rd_i, reg_rvalid_o, mism;
  logic [11:0]    reg_addr_i;
  logic [31:0]    reg_wdata_i, reg_rdata_o;
  tog_dev_state_t dev_state_i;
  logic           cfg_support_i, evlog_support_i, glimit_support_i;
  tog_rbuf_t      total_rbuf_i, glimit_o;
  logic           evt_valid_i, evt_swerr_i, evlog_wr_o, swerr_rec_o;
  logic           cmp_valid_i, cmp_user_i, cmp_intr_req_i, cmp_intr_o, cmp_blocked_o;
  tog_pasid_t     cmp_desc_pasid_i, cmp_entry_pasid_i;
  logic           rb_req_i, rb_low_bw_i, rb_use_global_i, rb_rel_i, rb_rel_global_i;
  logic           rb_grant_o, rb_deny_o, evlog_en_o, user_intr_en_o;
  logic [8:0]     rb_held_o;

  tog_regs #(.GRP_OFS(24'h001200), .WQ_OFS(24'h001300), .MSIX_OFS(24'h004500),
    .IMS_OFS(24'h00a000), .INTER_DOMAIN_PERMISSION_TABLE_OFS(24'hfe0000)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .dev_state_i(dev_state_i), .cfg_support_i(cfg_support_i),
    .evlog_support_i(evlog_support_i), .glimit_support_i(glimit_support_i),
    .total_rbuf_i(total_rbuf_i), .evt_valid_i(evt_valid_i), .evt_swerr_i(evt_swerr_i),
    .evlog_wr_o(evlog_wr_o), .swerr_rec_o(swerr_rec_o), .cmp_valid_i(cmp_valid_i),
    .cmp_user_i(cmp_user_i), .cmp_intr_req_i(cmp_intr_req_i),
    .cmp_desc_pasid_i(cmp_desc_pasid_i), .cmp_entry_pasid_i(cmp_entry_pasid_i),
    .cmp_intr_o(cmp_intr_o), .cmp_blocked_o(cmp_blocked_o), .rb_req_i(rb_req_i),
    .rb_low_bw_i(rb_low_bw_i), .rb_use_global_i(rb_use_global_i), .rb_rel_i(rb_rel_i),
    .rb_rel_global_i(rb_rel_global_i), .rb_grant_o(rb_grant_o), .rb_deny_o(rb_deny_o),
    .rb_held_o(rb_held_o), .evlog_en_o(evlog_en_o), .user_intr_en_o(user_intr_en_o),
    .glimit_o(glimit_o));

  // ************************************************************
  // clock, bus tasks and closing
  // ************************************************************
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i); #1;
    reg_wr_i = 1'b1; reg_addr_i = a; reg_wdata_i = d;
    @(posedge clk_i); #1;
    reg_wr_i = 1'b0;
  endtask

  // answer stands for one cycle only, so it is looked at right after the answering edge
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk_i); #1;
    reg_rd_i = 1'b1; reg_addr_i = a;
    @(posedge clk_i); #1;
    reg_rd_i = 1'b0;
    `CHK("rvalid", 1'b1, reg_rvalid_o);
    `CHK("rdata", e, reg_rdata_o);
  endtask

  // s = {evt,swerr,cmp,user,intr_req,pasid_mismatch,rb_req,low_bw,use_global,rel,rel_global}
  // e = {evlog_wr,swerr_rec,cmp_intr,cmp_blocked,rb_grant,rb_deny}
  task automatic act(input logic [10:0] s, input logic [5:0] e);
    @(posedge clk_i); #1;
    {evt_valid_i, evt_swerr_i, cmp_valid_i, cmp_user_i, cmp_intr_req_i, mism, rb_req_i,
     rb_low_bw_i, rb_use_global_i, rb_rel_i, rb_rel_global_i} = s;
    cmp_entry_pasid_i = mism ? 20'h00abd : 20'h00abc;
    @(posedge clk_i); #1;
    {evt_valid_i, evt_swerr_i, cmp_valid_i, cmp_user_i, cmp_intr_req_i, rb_req_i} = '0;
    {rb_low_bw_i, rb_use_global_i, rb_rel_i, rb_rel_global_i} = '0;
    `CHK("pulses", e, {evlog_wr_o, swerr_rec_o, cmp_intr_o, cmp_blocked_o, rb_grant_o,
      rb_deny_o});
  endtask

  task automatic end_sim();
    if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_i);
    errors++;
    end_sim();
  end

  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    errors = 0; checked = 0; rst_i = 1'b1; mism = 1'b0;
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, dev_state_i} = '0;
    {cfg_support_i, evlog_support_i, glimit_support_i} = 3'b111;
    total_rbuf_i = 8'h05; cmp_desc_pasid_i = 20'h00abc; cmp_entry_pasid_i = 20'h00abc;
    {evt_valid_i, evt_swerr_i, cmp_valid_i, cmp_user_i, cmp_intr_req_i, rb_req_i} = '0;
    {rb_low_bw_i, rb_use_global_i, rb_rel_i, rb_rel_global_i} = '0;
    repeat (8) @(posedge clk_i);
    #1 rst_i = 1'b0;
    rd(`TOG_ADDR_GENSET, 32'h0000_0005);
    `CHK("glimit", 8'h05, glimit_o);
    for (int i = 0; i < 8; i++) begin
      {dev_state_i, cfg_support_i, evlog_support_i, glimit_support_i} = rows[i][68:64];
      wr(`TOG_ADDR_GENSET, rows[i].wd);
      rd(`TOG_ADDR_GENSET, rows[i].rd);
      `CHK("user_intr_en", rows[i].rd[12], user_intr_en_o);
      `CHK("evlog_en", rows[i].rd[13], evlog_en_o);
      `CHK("glimit_o", rows[i].rd[7:0], glimit_o);
    end
    {dev_state_i, cfg_support_i, evlog_support_i, glimit_support_i} = 5'b00111;
    wr(12'h060, 32'hffff_ffff);
    // tables are found only through the directory words read here
    for (int i = 0; i < 5; i++) begin
      rd(12'(12'h060 + 4 * i), dir_exp[i]);
    end
    @(posedge clk_i); #1;
    `CHK("rvalid low", 1'b0, reg_rvalid_o);
    // log on, user interrupts off, limit of four buffers: one engine opts in
    wr(`TOG_ADDR_GENSET, 32'h0000_2004);
    act(11'b11000000000, 6'b000000);
    act(11'b00000011100, 6'b000000);
    dev_state_i = 2'h1;
    act(11'b11000000000, 6'b100000);
    act(11'b10000000000, 6'b100000);
    act(11'b00111000000, 6'b000100);
    for (int i = 0; i < 4; i++) begin
      act(11'b00000011100, 6'b000010);
    end
    act(11'b00000011100, 6'b000001);
    act(11'b00000011000, 6'b000010);
    act(11'b00000000011, 6'b000000);
    @(posedge clk_i); #1;
    `CHK("rb_held", 9'h003, rb_held_o);
    act(11'b00000011100, 6'b000010);
    // log off, user interrupts on
    dev_state_i = 2'h0;
    wr(`TOG_ADDR_GENSET, 32'h0000_1004);
    dev_state_i = 2'h1;
    act(11'b00111000000, 6'b001000);
    act(11'b00111100000, 6'b000100);
    act(11'b00101100000, 6'b001000);
    act(11'b11000000000, 6'b010000);
    // second reset in mid-run picks up a new buffer total
    total_rbuf_i = 8'h0c;
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1 rst_i = 1'b0;
    rd(`TOG_ADDR_GENSET, 32'h0000_000c);
    `CHK("glimit", 8'h0c, glimit_o);
    `CHK("rb_held", 9'h000, rb_held_o);
    end_sim();
  end
endmodule
`default_nettype wire
